// *** dv/imb_slave_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module imb_slave_model (
    // Clock and reset
    input  wire logic       ref_clk,
    input  wire logic       sys_rst,
    // Bus wires
    input  wire logic       scl,
    input  wire logic       sda,
    output logic            sda_pull,
    // Bench control
    input  wire logic       arm,
    input  wire logic       rx_mode,
    input  wire logic       ack_en,
    input  wire logic [7:0] tx_byte,
    output logic      [7:0] got_byte
);
    logic       scl_q;
    logic [3:0] cnt;

    // Bit count from SCL falls, saturating so idle never drives
    always_ff @(posedge ref_clk) begin
        scl_q <= scl;
        if (sys_rst || arm) begin
            cnt <= 4'h0;
        end else if (scl_q && !scl && cnt != 4'hf) begin
            cnt <= cnt + 4'h1;
        end
        if (!scl_q && scl && cnt < 4'h8) begin
            got_byte <= {got_byte[6:0], sda};
        end
    end

    always_comb begin
        if (rx_mode) begin
            sda_pull = (cnt < 4'h8) && !tx_byte[3'h7 - cnt[2:0]];
        end else begin
            sda_pull = (cnt == 4'h8) && ack_en;
        end
    end
endmodule : imb_slave_model
`default_nettype wire

// *** dv/tb_i2c_master_byte_transfer.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin bad_count++; \
    $display("BAD %s exp %h seen %h", nm, e, g); end end
module tb_i2c_master_byte_transfer;
    logic        ref_clk, sys_rst, psel, penable, pwrite, arm, rx_mode, ack_en, last_ack;
    logic [7:0]  paddr, tx_byte, got_byte, b;
    logic [31:0] pwdata, prdata, rdat;
    logic        pready, pslverr, perr, scl_oe, sda_oe, sda_pull, scl_w, sda_w, scl_ow, sda_ow;
    logic [6:0]  reload;
    int          bad_count, check_count, seed, hi_cnt, sda_cnt, n0, i;

    assign scl_w = scl_oe ? scl_ow : 1'b1;
    assign sda_w = (sda_oe ? sda_ow : 1'b1) && !sda_pull;

    imb_master dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .scl_i(scl_w), .scl_o(scl_ow), .scl_oe(scl_oe), .sda_i(sda_w),
        .sda_o(sda_ow), .sda_oe(sda_oe));

    imb_slave_model slv (.ref_clk(ref_clk), .sys_rst(sys_rst), .scl(scl_w), .sda(sda_w),
        .sda_pull(sda_pull), .arm(arm), .rx_mode(rx_mode), .ack_en(ack_en),
        .tx_byte(tx_byte), .got_byte(got_byte));

    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    // Released SCL cycles since arm, SDA pulled-low cycles overall
    always @(posedge ref_clk) begin
        hi_cnt <= arm ? 0 : hi_cnt + int'(!scl_oe);
        sda_cnt <= sda_cnt + int'(sda_oe);
    end

    ////////////////////////////////////////////////////////////
    task complete_run;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : complete_run

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        for (k = 0; k < 50; k++) begin
            @(posedge ref_clk);
            if (pready === 1'b1) break;
        end
        if (k == 50) begin
            bad_count++;
            complete_run();
        end
        rdat = prdata;
        perr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wait_idle;
        int k;
        for (k = 0; k < 400; k++) begin
            apb(1'b0, imb_pkg::ADDR_STATUS, 32'h0);
            if (rdat[imb_pkg::ST_BUSY] === 1'b0) break;
        end
        if (k == 400) begin
            bad_count++;
            complete_run();
        end
        // Let the synchronised pin levels settle before the final read
        repeat (8) @(posedge ref_clk);
        apb(1'b0, imb_pkg::ADDR_STATUS, 32'h0);
    endtask : wait_idle

    task kick;
        @(posedge ref_clk);
        arm <= 1'b1;
        @(posedge ref_clk);
        arm <= 1'b0;
    endtask : kick

    function automatic logic [31:0] st(input logic bf, irq, ack, write_collision_flag, ov);
        return {24'h0, 3'b100, ov, write_collision_flag, ack, irq, bf};
    endfunction : st

    ////////////////////////////////////////////////////////////
    initial begin
        #3000000;
        bad_count++;
        complete_run();
    end

    initial begin
        seed = 32'hdd4f;
        bad_count = 0;
        check_count = 0;
        hi_cnt = 0;
        sda_cnt = 0;
        sys_rst = 1'b1;
        {psel, penable, pwrite, arm, rx_mode, ack_en} = 6'h0;
        paddr = 8'h00;
        pwdata = 32'h0;
        tx_byte = 8'h00;
        repeat (6) @(posedge ref_clk);
        sys_rst <= 1'b0;
        apb(1'b0, imb_pkg::ADDR_STATUS, 32'h0);
        `CHK("status reset", st(0, 0, 0, 0, 0) | 32'h0000_0040, rdat)
        apb(1'b0, imb_pkg::ADDR_BAUD, 32'h0);
        `CHK("baud reset", {25'h0, imb_pkg::BAUD_RESET}, rdat)
        apb(1'b1, 8'h10, 32'h5a);
        `CHK("unmapped write err", 1'b1, perr)
        apb(1'b0, 8'h10, 32'h0);
        `CHK("unmapped read", 33'h100000000, {perr, rdat})
        // Transmit: ack then nack first, random after
        for (i = 0; i < 6; i++) begin
            reload = 7'h3 + 7'($unsigned($random(seed)) % 5);
            b = 8'($random(seed));
            ack_en <= (i == 0) ? 1'b1 : (i == 1) ? 1'b0 : 1'($random(seed));
            apb(1'b1, imb_pkg::ADDR_BAUD, {25'h0, reload});
            apb(1'b1, imb_pkg::ADDR_DATA, {24'h0, b});
            kick();
            apb(1'b1, imb_pkg::ADDR_DATA, 32'hff);
            apb(1'b1, imb_pkg::ADDR_CTRL, 32'h1);
            apb(1'b0, imb_pkg::ADDR_STATUS, 32'h0);
            `CHK("full and busy", 2'b11, {rdat[imb_pkg::ST_BUSY], rdat[imb_pkg::ST_BF]})
            wait_idle();
            `CHK("tx status", st(0, 1, !ack_en, 1, 0), rdat)
            `CHK("tx byte", b, got_byte)
            `CHK("tx released time", 9 * (int'(reload) + 1), hi_cnt)
            apb(1'b0, imb_pkg::ADDR_DATA, 32'h0);
            `CHK("tx buffer kept", {24'h0, b}, rdat)
            apb(1'b1, imb_pkg::ADDR_STATUS, 32'h1a);
        end
        last_ack = !ack_en;
        // Receive twice without reading: second overflows
        rx_mode <= 1'b1;
        for (i = 0; i < 2; i++) begin
            b = 8'($random(seed));
            tx_byte <= b;
            apb(1'b1, imb_pkg::ADDR_CTRL, 32'h1);
            kick();
            apb(1'b1, imb_pkg::ADDR_DATA, 32'h33);
            wait_idle();
            `CHK("rx status", st(1, 1, last_ack, 1, i == 1), rdat)
            `CHK("rx released time", 8 * (int'(reload) + 1), hi_cnt)
            apb(1'b1, imb_pkg::ADDR_STATUS, 32'h1a);
        end
        apb(1'b0, imb_pkg::ADDR_DATA, 32'h0);
        `CHK("rx data", {24'h0, b}, rdat)
        apb(1'b0, imb_pkg::ADDR_CTRL, 32'h0);
        `CHK("receive enable cleared", 1'b0, rdat[imb_pkg::CTRL_RECEIVE_ENABLE_BIT])
        apb(1'b0, imb_pkg::ADDR_STATUS, 32'h0);
        `CHK("full cleared by read", 1'b0, rdat[imb_pkg::ST_BF])
        apb(1'b1, imb_pkg::ADDR_STATUS, 32'h1a);
        // Ack sequence: ack value 0 pulls SDA, 1 leaves it
        for (i = 0; i < 2; i++) begin
            n0 = sda_cnt;
            apb(1'b1, imb_pkg::ADDR_CTRL, (i == 0) ? 32'h2 : 32'h6);
            wait_idle();
            `CHK("ack driven", i == 0, sda_cnt > n0)
            `CHK("ack irq", 1'b1, rdat[imb_pkg::ST_IRQ])
            apb(1'b1, imb_pkg::ADDR_STATUS, 32'h1a);
        end
        complete_run();
    end
endmodule : tb_i2c_master_byte_transfer
`default_nettype wire

// *** src/imb_baud_gen.sv ***
`timescale 1ns/1ps
`default_nettype none
module imb_baud_gen (
    // Clock and reset
    input  wire logic       ref_clk,
    input  wire logic       sys_rst,
    // Control
    input  wire logic       run,
    input  wire logic [6:0] reload,
    // Half period end
    output logic            tick
);
    logic [6:0] cnt_reg;

    assign tick = run && (cnt_reg == 7'h00);

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            cnt_reg <= imb_pkg::BAUD_RESET;
        end else if (!run || tick) begin
            cnt_reg <= reload;
        end else begin
            cnt_reg <= cnt_reg - 7'h01;
        end
    end
endmodule : imb_baud_gen
`default_nettype wire

// *** src/imb_master.sv ***
//Function
//- Buffer write sets full flag, starts shifting
//- SDA changes after fall; SCL low/high halves
//- Eighth fall clears full flag, releases SDA
//- Ninth fall samples SDA into ack status
//- After ninth clock: irq, hold SCL low
//- Address: seven bits plus direction, then ack
//- Transmit full flag: set on write, clear after eight
//- Write during transmit sets collision, discarded
//- Receive enable honoured only when idle
//- Receive toggles SCL per rollover, shifts SDA
//- Eighth receive fall: load buffer, flags, idle
//- Receive full flag cleared by buffer read
//- Ack enable sends ack bit after reception
//- Overflow when byte arrives with buffer full
//- Write during receive sets collision, discarded
//- Sequence bits and writes refused unless idle
//- Generator reloads seven-bit value at each rollover
//
// The implementer's own choices: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module imb_master (
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        sys_rst,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // I2C pins, open drain
    input  wire logic        scl_i,
    output logic             scl_o,
    output logic             scl_oe,
    input  wire logic        sda_i,
    output logic             sda_o,
    output logic             sda_oe
);
    imb_pkg::imb_state_t state_reg;

    logic [7:0] tx_rx_buffer_reg;
    logic [7:0] bus_shift_register_reg;
    logic [3:0] bit_cnt_reg;
    logic [6:0] baud_reload_value_reg;
    logic       sda_low_reg;
    logic       scl_hold_reg;
    logic       buffer_full_flag_reg;
    logic       serial_irq_flag_reg;
    logic       ack_status_bit_reg;
    logic       write_collision_flag_reg;
    logic       receive_overflow_flag_reg;
    logic       receive_enable_bit_reg;
    logic       ack_sequence_enable_reg;
    logic       ack_value_bit_reg;
    logic       pslverr_reg;
    logic       tick;
    logic       scl_s;
    logic       sda_s;
    logic [1:0] line_s;

    ////////////////////////////////////////////////////////////////////
    imb_pin_sync #(.W(2)) u_sync (
        .ref_clk   (ref_clk),
        .sys_rst   (sys_rst),
        .pin_in    ({scl_i, sda_i}),
        .level_out (line_s)
    );
    assign scl_s = line_s[1];
    assign sda_s = line_s[0];

    imb_baud_gen u_baud (
        .ref_clk (ref_clk),
        .sys_rst (sys_rst),
        .run     (state_reg != imb_pkg::S_IDLE),
        .reload  (baud_reload_value_reg),
        .tick    (tick)
    );

    ////////////////////////////////////////////////////////////////////
    logic       wr_acc;
    logic       rd_acc;
    logic       idle;
    logic       wr_data;
    logic       wr_ctrl;
    logic       wr_stat;
    logic       rd_data;
    logic       start_tx;
    logic       start_rx;
    logic       start_ack;
    logic       tx_fall;
    logic       rx_fall;
    logic       tx_8;
    logic       tx_9;
    logic       rx_8;
    logic       ak_done;
    logic       mapped;
    logic [7:0] rx_byte;

    assign wr_acc    = psel && penable && pwrite;
    assign rd_acc    = psel && penable && !pwrite;
    assign idle      = (state_reg == imb_pkg::S_IDLE);
    assign wr_data   = wr_acc && (paddr == imb_pkg::ADDR_DATA);
    assign wr_ctrl   = wr_acc && (paddr == imb_pkg::ADDR_CTRL);
    assign wr_stat   = wr_acc && (paddr == imb_pkg::ADDR_STATUS);
    assign rd_data   = rd_acc && (paddr == imb_pkg::ADDR_DATA);
    assign start_tx  = wr_data && idle;
    assign start_rx  = wr_ctrl && idle && pwdata[imb_pkg::CTRL_RECEIVE_ENABLE_BIT];
    assign start_ack = wr_ctrl && idle && pwdata[imb_pkg::CTRL_ACK_SEQUENCE_ENABLE]
                       && !pwdata[imb_pkg::CTRL_RECEIVE_ENABLE_BIT];
    assign tx_fall   = (state_reg == imb_pkg::S_TX_HIGH) && tick;
    assign rx_fall   = (state_reg == imb_pkg::S_RX_HIGH) && tick;
    assign tx_8      = tx_fall && (bit_cnt_reg == imb_pkg::BIT_LAST);
    assign tx_9      = tx_fall && (bit_cnt_reg == imb_pkg::BIT_ACK);
    assign rx_8      = rx_fall && (bit_cnt_reg == imb_pkg::BIT_LAST);
    assign ak_done   = (state_reg == imb_pkg::S_AK_HIGH) && tick;
    assign rx_byte   = {bus_shift_register_reg[6:0], sda_s};
    assign mapped    = (paddr == imb_pkg::ADDR_DATA) || (paddr == imb_pkg::ADDR_CTRL)
                       || (paddr == imb_pkg::ADDR_STATUS) || (paddr == imb_pkg::ADDR_BAUD);

    ////////////////////////////////////////////////////////////////////
    // Bit engine
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            state_reg              <= imb_pkg::S_IDLE;
            bit_cnt_reg            <= imb_pkg::BIT_FIRST;
            bus_shift_register_reg <= 8'h00;
            sda_low_reg            <= 1'b0;
        end else begin
            case (state_reg)
                imb_pkg::S_IDLE: begin
                    if (start_tx) begin
                        bus_shift_register_reg <= pwdata[7:0];
                        bit_cnt_reg            <= imb_pkg::BIT_FIRST;
                        sda_low_reg            <= !pwdata[7];
                        state_reg              <= imb_pkg::S_TX_LOW;
                    end else if (start_rx) begin
                        bit_cnt_reg <= imb_pkg::BIT_FIRST;
                        sda_low_reg <= 1'b0;
                        state_reg   <= imb_pkg::S_RX_LOW;
                    end else if (start_ack) begin
                        sda_low_reg <= !pwdata[imb_pkg::CTRL_ACK_VALUE_BIT];
                        state_reg   <= imb_pkg::S_AK_LOW;
                    end
                end
                imb_pkg::S_TX_LOW: begin
                    if (tick) begin
                        state_reg <= imb_pkg::S_TX_HIGH;
                    end
                end
                imb_pkg::S_TX_HIGH: begin
                    if (tx_9) begin
                        sda_low_reg <= 1'b0;
                        state_reg   <= imb_pkg::S_IDLE;
                    end else if (tx_8) begin
                        sda_low_reg <= 1'b0;
                        bit_cnt_reg <= imb_pkg::BIT_ACK;
                        state_reg   <= imb_pkg::S_TX_LOW;
                    end else if (tick) begin
                        bus_shift_register_reg <= {bus_shift_register_reg[6:0], 1'b0};
                        sda_low_reg            <= !bus_shift_register_reg[6];
                        bit_cnt_reg            <= bit_cnt_reg + 4'h1;
                        state_reg              <= imb_pkg::S_TX_LOW;
                    end
                end
                imb_pkg::S_RX_LOW: begin
                    if (tick) begin
                        state_reg <= imb_pkg::S_RX_HIGH;
                    end
                end
                imb_pkg::S_RX_HIGH: begin
                    if (tick) begin
                        bus_shift_register_reg <= rx_byte;
                        bit_cnt_reg            <= bit_cnt_reg + 4'h1;
                        state_reg              <= rx_8 ? imb_pkg::S_IDLE : imb_pkg::S_RX_LOW;
                    end
                end
                imb_pkg::S_AK_LOW: begin
                    if (tick) begin
                        state_reg <= imb_pkg::S_AK_HIGH;
                    end
                end
                imb_pkg::S_AK_HIGH: begin
                    if (tick) begin
                        sda_low_reg <= 1'b0;
                        state_reg   <= imb_pkg::S_IDLE;
                    end
                end
                default: begin
                    state_reg <= imb_pkg::S_IDLE;
                end
            endcase
        end
    end

    // SCL held low from the first byte on, between bytes too
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            scl_hold_reg <= 1'b0;
        end else if (!idle) begin
            scl_hold_reg <= 1'b1;
        end
    end

    assign scl_o  = 1'b0;
    assign sda_o  = 1'b0;
    assign scl_oe = (state_reg == imb_pkg::S_TX_LOW) || (state_reg == imb_pkg::S_RX_LOW)
                    || (state_reg == imb_pkg::S_AK_LOW) || (idle && scl_hold_reg);
    assign sda_oe = sda_low_reg;

    ////////////////////////////////////////////////////////////////////
    // Buffer and status flags; a hardware set wins over a clear
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            tx_rx_buffer_reg <= 8'h00;
        end else if (start_tx) begin
            tx_rx_buffer_reg <= pwdata[7:0];
        end else if (rx_8) begin
            tx_rx_buffer_reg <= rx_byte;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            buffer_full_flag_reg <= 1'b0;
        end else if (start_tx || rx_8) begin
            buffer_full_flag_reg <= 1'b1;
        end else if (tx_8 || (rd_data && idle)) begin
            buffer_full_flag_reg <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            serial_irq_flag_reg       <= 1'b0;
            write_collision_flag_reg  <= 1'b0;
            receive_overflow_flag_reg <= 1'b0;
        end else begin
            serial_irq_flag_reg <= (tx_9 || rx_8 || ak_done)
                || (serial_irq_flag_reg && !(wr_stat && pwdata[imb_pkg::ST_IRQ]));
            write_collision_flag_reg <= (wr_data && !idle)
                || (write_collision_flag_reg && !(wr_stat && pwdata[imb_pkg::ST_WRITE_COLLISION_FLAG]));
            receive_overflow_flag_reg <= (rx_8 && buffer_full_flag_reg)
                || (receive_overflow_flag_reg && !(wr_stat && pwdata[imb_pkg::ST_OV]));
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            ack_status_bit_reg <= 1'b0;
        end else if (tx_9) begin
            ack_status_bit_reg <= sda_s;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Control bits
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            receive_enable_bit_reg  <= 1'b0;
            ack_sequence_enable_reg <= 1'b0;
            ack_value_bit_reg       <= 1'b0;
            baud_reload_value_reg   <= imb_pkg::BAUD_RESET;
        end else begin
            if (start_rx) begin
                receive_enable_bit_reg <= 1'b1;
            end else if (rx_8) begin
                receive_enable_bit_reg <= 1'b0;
            end
            if (start_ack) begin
                ack_sequence_enable_reg <= 1'b1;
            end else if (ak_done) begin
                ack_sequence_enable_reg <= 1'b0;
            end
            if (wr_ctrl) begin
                ack_value_bit_reg <= pwdata[imb_pkg::CTRL_ACK_VALUE_BIT];
            end
            if (wr_acc && (paddr == imb_pkg::ADDR_BAUD)) begin
                baud_reload_value_reg <= pwdata[6:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // APB read data captured in the setup cycle
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            prdata      <= 32'h0000_0000;
            pslverr_reg <= 1'b0;
        end else if (psel && !penable) begin
            pslverr_reg <= !mapped;
            prdata      <= 32'h0000_0000;
            case (paddr)
                imb_pkg::ADDR_DATA: begin
                    prdata[7:0] <= tx_rx_buffer_reg;
                end
                imb_pkg::ADDR_CTRL: begin
                    prdata[imb_pkg::CTRL_RECEIVE_ENABLE_BIT]  <= receive_enable_bit_reg;
                    prdata[imb_pkg::CTRL_ACK_SEQUENCE_ENABLE] <= ack_sequence_enable_reg;
                    prdata[imb_pkg::CTRL_ACK_VALUE_BIT] <= ack_value_bit_reg;
                end
                imb_pkg::ADDR_STATUS: begin
                    prdata[imb_pkg::ST_BF]    <= buffer_full_flag_reg;
                    prdata[imb_pkg::ST_IRQ]   <= serial_irq_flag_reg;
                    prdata[imb_pkg::ST_ACKST] <= ack_status_bit_reg;
                    prdata[imb_pkg::ST_WRITE_COLLISION_FLAG]  <= write_collision_flag_reg;
                    prdata[imb_pkg::ST_OV]    <= receive_overflow_flag_reg;
                    prdata[imb_pkg::ST_BUSY]  <= !idle;
                    prdata[imb_pkg::ST_SCL]   <= scl_s;
                    prdata[imb_pkg::ST_SDA]   <= sda_s;
                end
                imb_pkg::ADDR_BAUD: begin
                    prdata[6:0] <= baud_reload_value_reg;
                end
                default: begin
                    prdata <= 32'h0000_0000;
                end
            endcase
        end
    end

    assign pready  = 1'b1;
    assign pslverr = psel && penable && pslverr_reg;

    ////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    AST_WRITE_STARTS_TX: assert property (start_tx |=> buffer_full_flag_reg
        && state_reg == imb_pkg::S_TX_LOW && tx_rx_buffer_reg == $past(pwdata[7:0]))
        else $error("buffer write did not start transmit");
    AST_SCL_LOW_HALF: assert property ((state_reg == imb_pkg::S_TX_LOW && !tick)
        |=> scl_oe && $stable(sda_oe))
        else $error("SCL or SDA moved in low half");
    AST_EIGHTH_FALL: assert property (tx_8 |=> !buffer_full_flag_reg && !sda_oe
        && bit_cnt_reg == imb_pkg::BIT_ACK)
        else $error("eighth fall did not release SDA");
    AST_ACK_SAMPLE: assert property (tx_9 |=> ack_status_bit_reg == $past(sda_s))
        else $error("ack status not sampled");
    AST_AFTER_NINTH: assert property (tx_9 |=> serial_irq_flag_reg && idle
        && scl_oe ##1 (scl_oe || !idle))
        else $error("no irq or SCL not held after ninth");
    AST_COLLISION: assert property ((wr_data && !idle && !rx_8) |=> write_collision_flag_reg
        && tx_rx_buffer_reg == $past(tx_rx_buffer_reg))
        else $error("collision not flagged or buffer changed");
    AST_RECEIVE_ENABLE_BIT_REFUSED: assert property ((wr_ctrl && !idle && !receive_enable_bit_reg)
        |=> !receive_enable_bit_reg)
        else $error("receive enable taken while busy");
    AST_RX_DONE: assert property (rx_8 |=> buffer_full_flag_reg && serial_irq_flag_reg
        && !receive_enable_bit_reg && idle && tx_rx_buffer_reg == $past(rx_byte))
        else $error("receive end incomplete");
    AST_OVERFLOW: assert property ((rx_8 && buffer_full_flag_reg) |=> receive_overflow_flag_reg)
        else $error("overflow not flagged");
    AST_READ_CLEARS: assert property ((rd_data && idle && !start_tx) |=> !buffer_full_flag_reg)
        else $error("buffer read did not clear full flag");

    COV_TX_BYTE: cover property (tx_9);
    COV_RX_BYTE: cover property (rx_8);
    COV_ACK_SEQ: cover property (ak_done);
    COV_WRITE_COLLISION_FLAG:    cover property (wr_data && !idle);
endmodule : imb_master
`default_nettype wire

// *** src/imb_pin_sync.sv ***
`timescale 1ns/1ps
`default_nettype none
module imb_pin_sync #(
    parameter int W = 2
) (
    // Clock and reset
    input  wire logic         ref_clk,
    input  wire logic         sys_rst,
    // Pins and filtered levels
    input  wire logic [W-1:0] pin_in,
    output logic      [W-1:0] level_out
);
    logic [W-1:0] s1_reg;
    logic [W-1:0] s2_reg;
    logic [W-1:0] s3_reg;

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            s1_reg <= '1;
            s2_reg <= '1;
            s3_reg <= '1;
        end else begin
            s1_reg <= pin_in;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    // A level counts once stages two and three agree
    for (genvar i = 0; i < W; i++) begin : g_bit
        always_ff @(posedge ref_clk) begin
            if (sys_rst) begin
                level_out[i] <= 1'b1;
            end else if (s2_reg[i] == s3_reg[i]) begin
                level_out[i] <= s3_reg[i];
            end
        end
    end
endmodule : imb_pin_sync
`default_nettype wire

// *** src/imb_pkg.sv ***
package imb_pkg;
    // Register byte addresses
    localparam logic [7:0] ADDR_DATA   = 8'h00;
    localparam logic [7:0] ADDR_CTRL   = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    localparam logic [7:0] ADDR_BAUD   = 8'h0c;

    // Control bits (bus_control_two)
    localparam int CTRL_RECEIVE_ENABLE_BIT  = 0;
    localparam int CTRL_ACK_SEQUENCE_ENABLE = 1;
    localparam int CTRL_ACK_VALUE_BIT = 2;

    // Status bits (serial_status_reg)
    localparam int ST_BF    = 0;
    localparam int ST_IRQ   = 1;
    localparam int ST_ACKST = 2;
    localparam int ST_WRITE_COLLISION_FLAG  = 3;
    localparam int ST_OV    = 4;
    localparam int ST_BUSY  = 5;
    localparam int ST_SCL   = 6;
    localparam int ST_SDA   = 7;

    localparam logic [6:0] BAUD_RESET = 7'h04;
    localparam logic [3:0] BIT_LAST   = 4'h7;
    localparam logic [3:0] BIT_ACK    = 4'h8;
    localparam logic [3:0] BIT_FIRST  = 4'h0;

    typedef enum logic [6:0] {
        S_IDLE    = 7'h01,
        S_TX_LOW  = 7'h02,
        S_TX_HIGH = 7'h04,
        S_RX_LOW  = 7'h08,
        S_RX_HIGH = 7'h10,
        S_AK_LOW  = 7'h20,
        S_AK_HIGH = 7'h40
    } imb_state_t;
endpackage : imb_pkg
